/* inc/sepr_pkg.sv */
// Shared constants and types for the serial EEPROM link
package sepr_pkg;
  localparam int SEPR_MEM_DEPTH = 128;
  localparam int SEPR_ADDR_W = 7;
  localparam logic [3:0] SEPR_CTRL_CODE = 4'hA;
  localparam logic [3:0] SEPR_SYNC_CYCLES = 4'h9;
  localparam logic [2:0] SEPR_BIT_LAST = 3'h7;
  localparam logic [6:0] SEPR_ADDR_RESET = 7'h00;
  localparam logic [7:0] SEPR_DATA_RESET = 8'hFF;
  // Self-timed write cycle length
  localparam int SEPR_WRITE_TIME_US = 5;
  localparam int SEPR_CLK_MHZ = 10;
  localparam logic [15:0] SEPR_WRITE_CYCLES = 16'(SEPR_WRITE_TIME_US * SEPR_CLK_MHZ);
  // Master phase timer limit: each serial clock phase lasts this plus one system clocks
  localparam logic [7:0] SEPR_HALF_PERIOD = 8'h14;
  typedef enum logic [1:0]
  {
    SEPR_OP_WRITE = 2'b00,
    SEPR_OP_READ = 2'b01,
    SEPR_OP_SETADDR = 2'b10,
    SEPR_OP_POLL = 2'b11
  } sepr_op_t;
endpackage

/* inc/sepr_if.sv */
// Two-wire link with open-drain resolution
`timescale 1ns/1ps
`default_nettype none
interface sepr_if;
  logic scl_oe_n;
  logic sda_m_oe_n;
  logic sda_s_oe_n;
  logic tx_clk;
  logic scl;
  logic sda;
  assign scl = scl_oe_n;
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport device
  (
    input scl,
    input sda,
    input tx_clk,
    output sda_s_oe_n
  );
  modport host
  (
    input scl,
    input sda,
    output scl_oe_n,
    output sda_m_oe_n,
    output tx_clk
  );
endinterface
`default_nettype wire

/* design/sepr_sync.sv */
// Two flip-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module sepr_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and result
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic meta_d;
  logic out_d;
  always_comb
  begin
    meta_d = din;
    out_d = meta_q;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      dout <= out_d;
    end
  end
endmodule // sepr_sync

/* design/sepr_device.sv */
// Serial EEPROM slave end: two modes, polling, protection, reads
// What this block does
// [R1] No acknowledge while write cycle runs
// [R2] Write control byte polls for completion
// [R3] STOP after write starts timed cycle
// [R4] Array writes only with transmit clock high
// [R5] Master sets direction bit one for reads
// [R6] Pointer holds last location plus one
// [R7] Read control acknowledged, data MSB first
// [R8] No master acknowledge then STOP ends read
// [R9] Address-only write loads pointer, no write
// [R10] Read after repeated START uses new address
// [R11] Master acknowledge continues sequential read
// [R12] Pointer increments after each byte; a write moves it once, at STOP
// [R13] Data changes with clock high are conditions
// [R14] Clock falling edge enters two-way mode
// [R15] Transmit-only: bit per transmit clock rise
// [R16] Data line is open drain only
// [R17] Control code 1010, three ignored, direction
// [R18] Nine silent clocks, MSB on tenth
// [R19] Seven-bit pointer wraps at 128
`timescale 1ns/1ps
`default_nettype none
module sepr_device
  import sepr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  sepr_if.device link,
  // Status
  output logic bidir_mode,
  output logic write_busy
);
  import sepr_pkg::*;
  typedef enum logic [2:0]
  {
    SEPR_ST_IDLE = 3'b000,
    SEPR_ST_CTRL = 3'b001,
    SEPR_ST_ADDR = 3'b010,
    SEPR_ST_WDATA = 3'b011,
    SEPR_ST_RDATA = 3'b100,
    SEPR_ST_MACK = 3'b101,
    SEPR_ST_ACK = 3'b110,
    SEPR_ST_IGNORE = 3'b111
  } sepr_state_t;

  logic [7:0] mem [SEPR_MEM_DEPTH];
  logic scl_s, sda_s, txclk_s;
  sepr_sync u_scl (.clk(clk), .rst_n(rst_n), .din(link.scl), .dout(scl_s));
  sepr_sync u_sda (.clk(clk), .rst_n(rst_n), .din(link.sda), .dout(sda_s));
  sepr_sync u_txclk (.clk(clk), .rst_n(rst_n), .din(link.tx_clk), .dout(txclk_s));

  sepr_state_t st_q, st_d, after_ack_q, after_ack_d;
  logic scl_q, sda_q, txclk_q;
  logic full_q, full_d;
  logic bidir_q, bidir_d;
  logic [3:0] sync_q, sync_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [6:0] ptr_q, ptr_d;
  logic [7:0] wbuf_q, wbuf_d;
  logic wpend_q, wpend_d;
  logic [15:0] busy_q, busy_d;
  logic oe_n_q, oe_n_d;
  logic we;
  logic start_c, stop_c, scl_rise, scl_fall, txclk_rise;

  assign start_c = scl_s && scl_q && sda_q && !sda_s; // R13
  assign stop_c = scl_s && scl_q && !sda_q && sda_s; // R13
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign txclk_rise = txclk_s && !txclk_q;
  assign link.sda_s_oe_n = oe_n_q; // R16
  assign bidir_mode = bidir_q;
  assign write_busy = busy_q != 16'h0000;

  always_comb
  begin
    st_d = st_q;
    after_ack_d = after_ack_q;
    bidir_d = bidir_q;
    sync_d = sync_q;
    bit_d = bit_q;
    full_d = full_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    wbuf_d = wbuf_q;
    wpend_d = wpend_q;
    busy_d = (busy_q != 16'h0000) ? busy_q - 16'h0001 : busy_q;
    oe_n_d = oe_n_q;
    we = 1'b0;
    if (!bidir_q)
    begin
      if (scl_fall)
      begin
        bidir_d = 1'b1; // R14
        oe_n_d = 1'b1;
        st_d = SEPR_ST_IDLE;
      end
      else if (txclk_rise)
      begin
        if (sync_q != SEPR_SYNC_CYCLES)
          sync_d = sync_q + 4'h1; // R18
        else
        begin
          oe_n_d = mem[ptr_q][3'(SEPR_BIT_LAST - bit_q)]; // R15
          bit_d = bit_q + 3'h1;
          if (bit_q == SEPR_BIT_LAST)
            ptr_d = ptr_q + 7'h01; // R19
        end
      end
    end
    else if (start_c)
    begin
      st_d = SEPR_ST_CTRL;
      full_d = 1'b0;
      bit_d = 3'h0;
      oe_n_d = 1'b1;
      wpend_d = 1'b0; // R9
    end
    else if (stop_c)
    begin
      st_d = SEPR_ST_IDLE;
      oe_n_d = 1'b1; // R8
      if (wpend_q)
      begin
        busy_d = SEPR_WRITE_CYCLES; // R3
        we = txclk_s; // R4
        ptr_d = ptr_q + 7'h01; // R6
        wpend_d = 1'b0;
      end
    end
    else if (scl_rise)
    begin
      case (st_q)
        SEPR_ST_CTRL, SEPR_ST_ADDR, SEPR_ST_WDATA:
        begin
          sh_d = {sh_q[6:0], sda_s};
          full_d = bit_q == SEPR_BIT_LAST;
          bit_d = bit_q + 3'h1;
        end
        SEPR_ST_MACK:
          if (sda_s)
            st_d = SEPR_ST_IGNORE;
          else
          begin
            st_d = SEPR_ST_ACK; // R11
            after_ack_d = SEPR_ST_RDATA;
          end
        default:
          st_d = st_q;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_q)
        SEPR_ST_CTRL:
          if (full_q)
          begin
            if (sh_q[7:4] == SEPR_CTRL_CODE && busy_q == 16'h0000) // R17 R1 R2
            begin
              oe_n_d = 1'b0;
              st_d = SEPR_ST_ACK;
              after_ack_d = sh_q[0] ? SEPR_ST_RDATA : SEPR_ST_ADDR; // R5
            end
            else
              st_d = SEPR_ST_IGNORE;
          end
        SEPR_ST_ADDR:
          if (full_q)
          begin
            ptr_d = sh_q[6:0]; // R9
            oe_n_d = 1'b0;
            st_d = SEPR_ST_ACK;
            after_ack_d = SEPR_ST_WDATA;
          end
        SEPR_ST_WDATA:
          if (full_q)
          begin
            wbuf_d = sh_q;
            wpend_d = 1'b1;
            oe_n_d = 1'b0;
            st_d = SEPR_ST_ACK;
            after_ack_d = SEPR_ST_WDATA;
          end
        SEPR_ST_ACK:
        begin
          st_d = after_ack_q;
          bit_d = 3'h0;
          oe_n_d = 1'b1;
          if (after_ack_q == SEPR_ST_RDATA)
          begin
            oe_n_d = mem[ptr_q][7]; // R7 R10
            bit_d = 3'h1;
          end
        end
        SEPR_ST_RDATA:
          if (bit_q == 3'h0)
          begin
            oe_n_d = 1'b1;
            ptr_d = ptr_q + 7'h01; // R12 R19
            st_d = SEPR_ST_MACK;
          end
          else
          begin
            oe_n_d = mem[ptr_q][3'(SEPR_BIT_LAST - bit_q)]; // R7
            bit_d = bit_q + 3'h1;
          end
        SEPR_ST_MACK:
          st_d = st_q;
        default:
          oe_n_d = 1'b1;
      endcase
    end
    else if (st_q == SEPR_ST_RDATA && !oe_n_q && bit_q == 3'h0)
      oe_n_d = oe_n_q;
  end

  always_ff @(posedge clk)
  begin
    if (we)
      mem[ptr_q] <= wbuf_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= SEPR_ST_IDLE;
      after_ack_q <= SEPR_ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      txclk_q <= 1'b1;
      full_q <= 1'b0;
      bidir_q <= 1'b0;
      sync_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= SEPR_ADDR_RESET;
      wbuf_q <= 8'h00;
      wpend_q <= 1'b0;
      busy_q <= 16'h0000;
      oe_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      after_ack_q <= after_ack_d;
      scl_q <= scl_s;
      sda_q <= sda_s;
      txclk_q <= txclk_s;
      full_q <= full_d;
      bidir_q <= bidir_d;
      sync_q <= sync_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      wbuf_q <= wbuf_d;
      wpend_q <= wpend_d;
      busy_q <= busy_d;
      oe_n_q <= oe_n_d;
    end
  end
endmodule // sepr_device
`default_nettype wire

/* design/sepr_host.sv */
// Bus master end: runs one operation per request
`timescale 1ns/1ps
`default_nettype none
module sepr_host
  import sepr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  sepr_if.host link,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire sepr_pkg::sepr_op_t req_op,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic [7:0] req_count,
  input wire logic wp_n,
  // Answer
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import sepr_pkg::*;
  typedef enum logic [2:0]
  {
    SEPR_H_IDLE = 3'b000,
    SEPR_H_START = 3'b001,
    SEPR_H_BIT = 3'b010,
    SEPR_H_STOP = 3'b011,
    SEPR_H_DONE = 3'b100
  } sepr_hstate_t;
  logic sda_s;
  sepr_sync u_sda (.clk(clk), .rst_n(rst_n), .din(link.sda), .dout(sda_s));
  sepr_hstate_t st_q, st_d;
  logic [7:0] tmr_q, tmr_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] byte_q, byte_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  sepr_op_t op_q, op_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic scl_q, scl_d, sda_q, sda_d, nack_q, nack_d, rd_q, rd_d;
  logic [7:0] buf0_q, buf0_d;
  logic [1:0] fill_q, fill_d;
  logic [7:0] buf1_q, buf1_d;
  logic push, pop, tick;
  assign link.scl_oe_n = scl_q;
  assign link.sda_m_oe_n = sda_q;
  assign link.tx_clk = wp_n; // R4
  assign req_ready = st_q == SEPR_H_IDLE;
  assign rsp_valid = fill_q != 2'b00;
  assign rsp_data = buf0_q;
  assign rsp_nack = nack_q;
  assign tick = tmr_q == SEPR_HALF_PERIOD;
  assign pop = rsp_valid && rsp_ready;
  always_comb
  begin
    st_d = st_q;
    tmr_d = tick ? 8'h00 : tmr_q + 8'h01;
    ph_d = ph_q;
    bit_d = bit_q;
    byte_d = byte_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    scl_d = scl_q;
    sda_d = sda_q;
    nack_d = nack_q;
    rd_d = rd_q;
    push = 1'b0;
    case (st_q)
      SEPR_H_IDLE:
        if (req_valid)
        begin
          op_d = req_op;
          addr_d = req_addr;
          data_d = req_data;
          cnt_d = req_count;
          nack_d = 1'b0;
          byte_d = 3'h0;
          rd_d = req_op == SEPR_OP_READ;
          st_d = SEPR_H_START;
          ph_d = 2'b00;
          tmr_d = 8'h00;
        end
      SEPR_H_START:
        if (tick)
        begin
          ph_d = ph_q + 2'b01;
          case (ph_q)
            2'b00:
            begin
              sda_d = 1'b1;
              scl_d = 1'b1;
            end
            2'b01: sda_d = 1'b0; // R13
            default:
            begin
              scl_d = 1'b0;
              sh_d = {SEPR_CTRL_CODE, 3'b000, rd_q}; // R5 R17
              bit_d = 4'h0;
              ph_d = 2'b00;
              st_d = SEPR_H_BIT;
              byte_d = 3'h0;
            end
          endcase
        end
      SEPR_H_BIT:
        if (tick)
        begin
          ph_d = ph_q + 2'b01;
          case (ph_q)
            2'b00: sda_d = (bit_q == 4'h8) ? !(rd_q && byte_q != 3'h0 && cnt_q != 8'h00)
              : (rd_q && byte_q != 3'h0) ? 1'b1 : sh_q[7];
            2'b01: scl_d = 1'b1;
            default:
            begin
              scl_d = 1'b0;
              ph_d = 2'b00;
              if (bit_q != 4'h8)
              begin
                sh_d = {sh_q[6:0], sda_s};
                bit_d = bit_q + 4'h1;
              end
              else
              begin
                bit_d = 4'h0;
                byte_d = (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
                if (!(rd_q && byte_q != 3'h0) && sda_s)
                begin
                  nack_d = 1'b1; // R1 R2
                  st_d = SEPR_H_STOP;
                end
                else if (rd_q && byte_q != 3'h0)
                begin
                  push = 1'b1;
                  if (cnt_q == 8'h00)
                    st_d = SEPR_H_STOP; // R8
                  else
                    cnt_d = cnt_q - 8'h01; // R11
                end
                else if (op_q == SEPR_OP_POLL || (rd_q && byte_q == 3'h0))
                  st_d = (op_q == SEPR_OP_POLL) ? SEPR_H_STOP : SEPR_H_BIT;
                else if (byte_q == 3'h0)
                  sh_d = {1'b0, addr_q};
                else if (byte_q == 3'h1 && op_q == SEPR_OP_WRITE)
                  sh_d = data_q;
                else if (byte_q == 3'h1)
                begin
                  rd_d = 1'b1; // R9 R10
                  st_d = SEPR_H_START;
                  sda_d = 1'b1;
                end
                else
                  st_d = SEPR_H_STOP; // R3
              end
            end
          endcase
        end
      SEPR_H_STOP:
        if (tick)
        begin
          ph_d = ph_q + 2'b01;
          case (ph_q)
            2'b00: sda_d = 1'b0;
            2'b01: scl_d = 1'b1;
            default:
            begin
              sda_d = 1'b1; // R13
              ph_d = 2'b00;
              st_d = SEPR_H_DONE;
            end
          endcase
        end
      default:
        if (fill_q != 2'b10)
          st_d = SEPR_H_IDLE;
    endcase
  end
  always_comb
  begin
    fill_d = fill_q;
    buf0_d = buf0_q;
    buf1_d = buf1_q;
    if (pop)
    begin
      buf0_d = buf1_q;
      fill_d = fill_q - 2'b01;
    end
    if (push)
    begin
      if (fill_d == 2'b00)
        buf0_d = sh_q;
      else
        buf1_d = sh_q;
      fill_d = fill_d + 2'b01;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= SEPR_H_IDLE;
      tmr_q <= 8'h00;
      ph_q <= 2'b00;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      cnt_q <= 8'h00;
      sh_q <= 8'h00;
      op_q <= SEPR_OP_WRITE;
      addr_q <= SEPR_ADDR_RESET;
      data_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
      rd_q <= 1'b0;
      fill_q <= 2'b00;
      buf0_q <= 8'h00;
      buf1_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      nack_q <= nack_d;
      rd_q <= rd_d;
      fill_q <= fill_d;
      buf0_q <= buf0_d;
      buf1_q <= buf1_d;
    end
  end
endmodule // sepr_host
`default_nettype wire

/* sim/sepr_properties.sv */
// Link properties for the serial EEPROM link
`timescale 1ns/1ps
`default_nettype none
module sepr_properties
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  input wire logic scl_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic tx_clk,
  input wire logic scl,
  input wire logic sda,
  // Device status
  input wire logic bidir_mode,
  input wire logic write_busy
);
  logic [4:0] rise_q;
  logic [4:0] rise_d;
  logic [3:0] age_q;
  logic [3:0] age_d;
  logic [5:0] hi_q;
  logic [5:0] hi_d;
  logic [7:0] busy_q;
  logic [7:0] busy_d;
  logic tx_q;
  // Transmit clock rises, idle time and busy length
  always_comb
  begin
    rise_d = rise_q;
    age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
    if (tx_clk && !tx_q)
    begin
      age_d = 4'h0;
      if (!bidir_mode && rise_q != 5'h1F)
        rise_d = rise_q + 5'h01;
    end
    hi_d = !scl ? 6'h00 : (hi_q == 6'h3F) ? hi_q : hi_q + 6'h01;
    busy_d = write_busy ? busy_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk)
  begin
    tx_q <= tx_clk;
    if (!rst_n)
    begin
      rise_q <= 5'h00;
      age_q <= 4'hF;
      hi_q <= 6'h00;
      busy_q <= 8'h00;
    end
    else
    begin
      rise_q <= rise_d;
      age_q <= age_d;
      hi_q <= hi_d;
      busy_q <= busy_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_low_phase;
    (!scl_oe_n) [*8];
  endsequence
  sequence s_bus_idle;
    scl && sda;
  endsequence
  property p_busy_quiet;
    write_busy && $past(write_busy) |-> sda_s_oe_n;
  endproperty
  property p_cycle_after_stop;
    $rose(write_busy) |-> s_bus_idle;
  endproperty
  property p_cycle_len;
    $fell(write_busy) |-> busy_q inside {8'h32, 8'h33};
  endproperty
  property p_idle_release;
    bidir_mode && hi_q > 6'h1E |-> sda_s_oe_n;
  endproperty
  property p_dev_change_low;
    bidir_mode && $changed(sda_s_oe_n) |-> !scl;
  endproperty
  property p_host_low;
    $fell(scl_oe_n) |-> s_low_phase;
  endproperty
  property p_enter_bidir;
    $fell(scl) && !bidir_mode |-> ##[1:6] bidir_mode;
  endproperty
  property p_stay_bidir;
    bidir_mode |=> bidir_mode;
  endproperty
  property p_tx_on_rise;
    !bidir_mode && scl && $changed(sda_s_oe_n) |-> age_q < 4'h7;
  endproperty
  property p_sync_silent;
    !bidir_mode && rise_q < 5'h0A |-> sda_s_oe_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  a_cycle_after_stop: assert property (p_cycle_after_stop) else $error("cycle not at STOP");
  a_cycle_len: assert property (p_cycle_len) else $error("write cycle length");
  a_idle_release: assert property (p_idle_release) else $error("data held on idle bus");
  a_dev_change_low: assert property (p_dev_change_low) else $error("device data moved");
  a_host_low: assert property (p_host_low) else $error("short clock low");
  a_enter_bidir: assert property (p_enter_bidir) else $error("no mode switch");
  a_stay_bidir: assert property (p_stay_bidir) else $error("mode fell back");
  a_tx_on_rise: assert property (p_tx_on_rise) else $error("stream bit off edge");
  a_sync_silent: assert property (p_sync_silent) else $error("drive during sync");
endmodule // sepr_properties
`default_nettype wire

/* sim/tb_serial_eeprom_read_and_poll.sv */
// Bench joining host and device ends of the link
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_read_and_poll;
  import sepr_pkg::*;
  logic clk;
  logic rst_n;
  logic req_valid;
  logic req_ready;
  sepr_op_t req_op;
  logic [6:0] req_addr;
  logic [7:0] req_data;
  logic [7:0] req_count;
  logic wp_n;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic bidir_mode;
  logic write_busy;
  logic [15:0] stream;
  logic [7:0] rx_q[$];
  int err_total;
  int n_tests;
  sepr_if link();
  sepr_host u_sepr_host (.clk(clk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_count(req_count), .wp_n(wp_n), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  sepr_device u_sepr_device (.clk(clk), .rst_n(rst_n), .link(link),
    .bidir_mode(bidir_mode), .write_busy(write_busy));
  sepr_properties u_sepr_properties (.clk(clk), .rst_n(rst_n), .scl_oe_n(link.scl_oe_n),
    .sda_s_oe_n(link.sda_s_oe_n), .tx_clk(link.tx_clk), .scl(link.scl), .sda(link.sda),
    .bidir_mode(bidir_mode), .write_busy(write_busy));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Collect popped read words
  always @(posedge clk)
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
      rx_q.push_back(rsp_data);
  task automatic end_sim;
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %b seen %b", what, exp, got);
      err_total++;
    end
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task automatic run_op(input sepr_op_t op, input logic [6:0] addr, input logic [7:0] data,
    input logic [7:0] count);
    int i;
    int idle;
    req_op = op;
    req_addr = addr;
    req_data = data;
    req_count = count;
    req_valid = 1'b1;
    i = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && i < 100)
    begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
    i = 0;
    @(negedge clk);
    idle = 0;
    while (req_ready !== 1'b1 && idle < 100 && i < 20000)
    begin
      @(negedge clk);
      idle = (link.scl === 1'b1 && link.sda === 1'b1) ? idle + 1 : 0;
      i++;
    end
    chk_bit("req_ready", rsp_ready, req_ready);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic write_poll(input logic [6:0] addr, input logic [7:0] data);
    run_op(SEPR_OP_WRITE, addr, data, 8'h00);
    run_op(SEPR_OP_POLL, 7'h00, 8'h00, 8'h00);
    chk_bit("poll rsp_nack", 1'b0, rsp_nack);
  endtask
  task automatic read_chk(input sepr_op_t op, input logic [6:0] addr, input logic [7:0] exp[$]);
    rx_q.delete();
    run_op(op, addr, 8'h00, 8'(exp.size() - 1));
    if (rsp_ready !== 1'b1)
    begin
      chk_bit("held rsp_valid", 1'b1, rsp_valid);
      chk_bit("nothing popped", 1'b1, rx_q.size() == 0);
      rsp_ready = 1'b1;
      repeat (4) @(posedge clk);
      #1;
    end
    chk_bit("word count", 1'b1, rx_q.size() == exp.size());
    foreach (exp[k])
      chk_byte("rsp_data", exp[k], (k < rx_q.size()) ? rx_q[k] : 8'hXX);
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial
  begin
    err_total = 0;
    n_tests = 0;
    req_valid = 1'b0;
    req_op = SEPR_OP_WRITE;
    req_addr = 7'h00;
    req_data = 8'h00;
    req_count = 8'h00;
    wp_n = 1'b1;
    rsp_ready = 1'b1;
    stream = 16'h0000;
    do_reset();
    run_op(SEPR_OP_POLL, 7'h00, 8'h00, 8'h00);
    chk_bit("first rsp_nack", 1'b1, rsp_nack);
    chk_bit("first bidir_mode", 1'b1, bidir_mode);
    write_poll(7'h00, 8'hA5);
    write_poll(7'h01, 8'h3C);
    write_poll(7'h7F, 8'h5A);
    read_chk(SEPR_OP_READ, 7'h00, {8'hA5});
    read_chk(SEPR_OP_SETADDR, 7'h7F, {8'h5A, 8'hA5, 8'h3C});
    read_chk(SEPR_OP_SETADDR, 7'h00, {8'hA5});
    read_chk(SEPR_OP_READ, 7'h00, {8'h3C});
    wp_n = 1'b0;
    write_poll(7'h01, 8'h00);
    wp_n = 1'b1;
    rsp_ready = 1'b0;
    read_chk(SEPR_OP_SETADDR, 7'h00, {8'hA5, 8'h3C});
    do_reset();
    chk_bit("bidir_mode", 1'b0, bidir_mode);
    wp_n = 1'b0;
    for (int r = 1; r <= 26; r++)
    begin
      repeat (4) @(posedge clk);
      #1;
      if (r >= 11)
        stream = {stream[14:0], link.sda};
      wp_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 wp_n = 1'b0;
    end
    chk_byte("stream first", 8'hA5, stream[15:8]);
    chk_byte("stream second", 8'h3C, stream[7:0]);
    wp_n = 1'b1;
    run_op(SEPR_OP_POLL, 7'h00, 8'h00, 8'h00);
    chk_bit("bidir_mode", 1'b1, bidir_mode);
    run_op(SEPR_OP_POLL, 7'h00, 8'h00, 8'h00);
    chk_bit("poll rsp_nack", 1'b0, rsp_nack);
    end_sim();
  end
endmodule // tb_serial_eeprom_read_and_poll
`default_nettype wire
